// *** bench/eip_core_model.sv ***
// Core-side model: takes offered interrupts and ends service on command
`timescale 1ns/1ps
`default_nettype none
module eip_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Offer and bench commands
    input wire logic irq_req,
    input wire logic serve,
    input wire logic done,
    // Handshake
    output logic irq_ack,
    output logic irq_reti
);
    logic want_q;
    logic take;
    // One ack per command: the offer lags the ack by a cycle
    assign take = want_q && irq_req && !irq_ack;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            want_q <= 1'b0;
            irq_ack <= 1'b0;
            irq_reti <= 1'b0;
        end else begin
            want_q <= (want_q || serve) && !take;
            irq_ack <= take;
            irq_reti <= done;
        end
    end
endmodule
`default_nettype wire

// *** bench/eip_top_monitor.sv ***
// Concurrent checks on the ports of the interrupt enable/priority block
`timescale 1ns/1ps
`default_nettype none
module eip_top_monitor
    import eip_pkg::*;
#(
    parameter int NSRC = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register bus
    input wire eip_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Sources, core side, masked vector and register contents
    input wire eip_src_s src,
    input wire logic irq_ack,
    input wire logic irq_reti,
    input wire logic irq_req,
    input wire logic irq_high,
    input wire logic [NSRC-1:0] irq_sel,
    input wire logic [NSRC-1:0] irq_pending,
    input wire logic [7:0] enable_out,
    input wire logic [7:0] priority_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ==========
    // Source groups in enable-bit order
    logic [7:0] grp;
    logic mapped;
    assign grp = {src[11] | src[10], src[9] | src[8], src[7] | src[6], src[5:3],
        src[2] | src[1], src[0]};
    assign mapped = sfr_req.addr == 8'hE6 || sfr_req.addr == 8'hF6;
    // ==========
    // Checks
    a_pend_mask: assert property (irq_pending ==
        ($past(resetn) ? $past(grp & enable_out) : 8'h00))
        else $error("masked vector wrong");
    a_en_write: assert property (sfr_req.wr && sfr_req.addr == 8'hE6
        |=> sfr_hit && enable_out == $past(sfr_req.wdata)) else $error("enable write lost");
    a_pri_write: assert property (sfr_req.wr && sfr_req.addr == 8'hF6
        |=> sfr_hit && priority_out == $past(sfr_req.wdata)) else $error("priority write lost");
    a_read_back: assert property (sfr_req.rd && sfr_req.addr == 8'hE6
        |=> sfr_rdata == $past(enable_out)) else $error("read data wrong");
    a_miss_quiet: assert property ((sfr_req.wr || sfr_req.rd) && !mapped
        |=> !sfr_hit && sfr_rdata == 8'h00 && $stable(enable_out) && $stable(priority_out))
        else $error("unmapped access had effect");
    a_high_flag: assert property (irq_req
        |-> irq_high == |(irq_sel & $past(priority_out))) else $error("level flag wrong");
    a_sel_onehot: assert property (irq_req |-> $onehot(irq_sel))
        else $error("selection not one-hot");
    a_high_hold: assert property (irq_ack && irq_req && irq_high |=> ##1 !irq_req)
        else $error("offer during high service");
    a_rst_clear: assert property (disable iff (1'b0) !resetn
        |=> enable_out == 8'h00 && priority_out == 8'h00 && !irq_req)
        else $error("reset state wrong");
    c_high: cover property (irq_req && irq_high);
    c_low_ack: cover property (irq_ack && irq_req && !irq_high);
    c_hit: cover property (sfr_hit);
endmodule
bind eip_top eip_top_monitor #(.NSRC(NSRC)) u_mon (.mclk(mclk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .src(src),
    .irq_ack(irq_ack), .irq_reti(irq_reti), .irq_req(irq_req), .irq_high(irq_high),
    .irq_sel(irq_sel), .irq_pending(irq_pending), .enable_out(enable_out),
    .priority_out(priority_out));
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the interrupt enable/priority block
`timescale 1ns/1ps
`default_nettype none
module tb_top import eip_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    eip_sfr_req_s sfr_req = '0;
    eip_src_s src = '0;
    logic serve = 1'b0;
    logic done = 1'b0;
    logic irq_ack, irq_reti, irq_req, irq_high, sfr_hit;
    logic [7:0] sfr_rdata, irq_sel, irq_pending, enable_out, priority_out;
    int failures = 0;
    int tests_run = 0;
    int bmap [0:11] = '{0, 1, 1, 2, 3, 4, 5, 5, 6, 6, 7, 7};
    initial forever #4 mclk = ~mclk;
    eip_top dut (.mclk(mclk), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .src(src), .irq_ack(irq_ack), .irq_reti(irq_reti),
        .irq_req(irq_req), .irq_high(irq_high), .irq_sel(irq_sel),
        .irq_pending(irq_pending), .enable_out(enable_out), .priority_out(priority_out));
    eip_core_model core (.mclk(mclk), .resetn(resetn), .irq_req(irq_req), .serve(serve),
        .done(done), .irq_ack(irq_ack), .irq_reti(irq_reti));
    // ==========
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) sfr_req <= '{w, !w, a, d};
        @(posedge mclk) sfr_req <= '0;
        #1;
    endtask
    task automatic set_en(input logic [7:0] v, input logic [7:0] exp);
        acc(1'b1, 8'hE6, v);
        @(posedge mclk);
        #1;
        chk("pending", exp, irq_pending);
    endtask
    task automatic wait_req(input logic exp);
        int n;
        #1;
        for (n = 0; n < 20 && irq_req !== exp; n++) begin
            @(posedge mclk);
            #1;
        end
        chk("irq_req", {7'h00, exp}, {7'h00, irq_req});
        if (irq_req !== exp) wrap_up();
    endtask
    task automatic pulse(input logic s);
        @(posedge mclk) begin
            serve <= s;
            done <= !s;
        end
        @(posedge mclk) begin
            serve <= 1'b0;
            done <= 1'b0;
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_regs;
        chk("en_rst", 8'h00, enable_out);
        chk("pri_rst", 8'h00, priority_out);
        acc(1'b1, 8'hE6, 8'hA5);
        acc(1'b1, 8'hF6, 8'h5A);
        acc(1'b0, 8'hE6, 8'h00);
        chk("rd_en", 8'hA5, sfr_rdata);
        chk("hit_rd", 8'h01, {7'h00, sfr_hit});
        acc(1'b0, 8'hF6, 8'h00);
        chk("rd_pri", 8'h5A, sfr_rdata);
        acc(1'b1, 8'hE7, 8'hFF);
        acc(1'b0, 8'hE7, 8'h00);
        chk("rd_miss", 8'h00, sfr_rdata);
        chk("hit_miss", 8'h00, {7'h00, sfr_hit});
        chk("en_kept", 8'hA5, enable_out);
    endtask
    task automatic t_mask;
        int j;
        for (j = 0; j < 12; j++) begin
            @(posedge mclk) src <= eip_src_s'(12'h001 << j);
            set_en(~(8'h01 << bmap[j]), 8'h00);
            set_en(8'h01 << bmap[j], 8'h01 << bmap[j]);
            set_en(8'h00, 8'h00);
            set_en(8'h01 << bmap[j], 8'h01 << bmap[j]);
        end
        @(posedge mclk) src <= '0;
    endtask
    task automatic t_prio;
        acc(1'b1, 8'hF6, 8'h01);
        acc(1'b1, 8'hE6, 8'hFF);
        @(posedge mclk) src.adc_done_flag <= 1'b1;
        wait_req(1'b1);
        chk("sel_low", 8'h08, irq_sel);
        chk("lvl_low", 8'h00, {7'h00, irq_high});
        pulse(1'b1);
        wait_req(1'b0);
        @(posedge mclk) src.twowire_req <= 1'b1;
        wait_req(1'b1);
        chk("sel_high", 8'h01, irq_sel);
        chk("lvl_high", 8'h01, {7'h00, irq_high});
        pulse(1'b1);
        wait_req(1'b0);
        @(posedge mclk) src.twowire_req <= 1'b0;
        pulse(1'b0);
        repeat (4) @(posedge mclk);
        #1;
        chk("low_held", 8'h00, {7'h00, irq_req});
        pulse(1'b0);
        wait_req(1'b1);
        chk("sel_back", 8'h08, irq_sel);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        #1;
        t_regs();
        t_mask();
        t_prio();
        wrap_up();
    end
endmodule
`default_nettype wire

// *** rtl/eip_arbiter.sv ***
// Two-level priority arbiter with preemption tracking
`timescale 1ns/1ps
`default_nettype none
module eip_arbiter
    import eip_pkg::*;
#(
    parameter int NSRC = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Masked requests and priority levels
    input wire logic [NSRC-1:0] req,
    input wire logic [NSRC-1:0] prio,
    // Core service handshake
    input wire logic ack,
    input wire logic reti,
    // Selection
    output logic sel_valid,
    output logic [NSRC-1:0] sel_onehot,
    output logic sel_high,
    output eip_level_e level
);

    // ==========================================================
    // Selection
    function automatic logic [NSRC-1:0] lowest_set(input logic [NSRC-1:0] v);
        logic [NSRC-1:0] r;
        r = v & (~v + 1'b1);
        return r;
    endfunction

    wire logic [NSRC-1:0] hi_req = req & prio;
    wire logic [NSRC-1:0] lo_req = req & ~prio;
    wire logic any_hi = |hi_req;
    wire logic any_lo = |lo_req;
    eip_level_e level_q;
    eip_level_e level_d;
    logic low_saved_q;
    logic low_saved_d;

    // High can interrupt low service, low never interrupts high
    wire logic hi_ok = any_hi && (level_q != EIP_HIGH);
    wire logic lo_ok = any_lo && !any_hi && (level_q == EIP_IDLE);
    assign sel_valid = hi_ok || lo_ok;
    assign sel_high = hi_ok;
    assign sel_onehot = hi_ok ? lowest_set(hi_req) : (lo_ok ? lowest_set(lo_req) : '0);
    assign level = level_q;

    // ==========================================================
    // Service level tracking
    always_comb begin
        level_d = level_q;
        low_saved_d = low_saved_q;
        if (ack && hi_ok) begin
            low_saved_d = (level_q == EIP_LOW);
            level_d = EIP_HIGH;
        end else if (ack && lo_ok) begin
            level_d = EIP_LOW;
        end else if (reti) begin
            unique case (level_q)
                EIP_HIGH: begin
                    level_d = low_saved_q ? EIP_LOW : EIP_IDLE;
                    low_saved_d = 1'b0;
                end
                EIP_LOW: level_d = EIP_IDLE;
                EIP_IDLE: level_d = EIP_IDLE;
                default: level_d = EIP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            level_q <= EIP_IDLE;
            low_saved_q <= 1'b0;
        end else begin
            level_q <= level_d;
            low_saved_q <= low_saved_d;
        end
    end

    if (NSRC < 1 || NSRC > 8) begin : g_bad_nsrc
        $error("eip_arbiter: NSRC must be 1..8");
    end

endmodule
`default_nettype wire

// *** rtl/eip_defines.svh ***
// Offsets, field positions and reset values of the extended interrupt enable/priority block
`ifndef EIP_DEFINES_SVH
`define EIP_DEFINES_SVH

// ==========================================================
// Register addresses on the special-function bus
`define EIP_ADDR_ENABLE_ONE 8'hE6
`define EIP_ADDR_PRIORITY_ONE 8'hF6

// ==========================================================
// Reset values
`define EIP_RESET_ENABLE_ONE 8'h00
`define EIP_RESET_PRIORITY_ONE 8'h00

// ==========================================================
// Source bit positions, shared by both registers
`define EIP_BIT_TIMER3 7
`define EIP_BIT_CMP1 6
`define EIP_BIT_CMP0 5
`define EIP_BIT_COUNTER_ARRAY 4
`define EIP_BIT_ADC_DONE 3
`define EIP_BIT_ADC_WINDOW 2
`define EIP_BIT_RTC 1
`define EIP_BIT_TWOWIRE 0

`endif

// *** rtl/eip_pkg.sv ***
// Types of the extended interrupt enable/priority block
package eip_pkg;

    // ==========================================================
    // Raw request lines from the peripherals
    typedef struct packed {
        logic timer3_low_overflow_flag;
        logic timer3_high_overflow_flag;
        logic cmp1_rise_flag;
        logic cmp1_fall_flag;
        logic cmp0_rise_flag;
        logic cmp0_fall_flag;
        logic counter_array_req;
        logic adc_done_flag;
        logic adc_window_flag;
        logic rtc_alarm_flag;
        logic rtc_osc_fail_flag;
        logic twowire_req;
    } eip_src_s;

    // ==========================================================
    // Special-function register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eip_sfr_req_s;

    typedef logic [7:0] eip_vec_t;

    // Arbiter service level
    typedef enum logic [2:0] {
        EIP_IDLE = 3'b001,
        EIP_LOW  = 3'b010,
        EIP_HIGH = 3'b100
    } eip_level_e;

endpackage

// *** rtl/eip_top.sv ***
// Extended interrupt enable and priority registers with masked request routing
`timescale 1ns/1ps
`default_nettype none
`include "eip_defines.svh"
module eip_top
    import eip_pkg::*;
#(
    parameter int NSRC = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Special-function register bus
    input wire eip_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Peripheral requests
    input wire eip_src_s src,
    // Core interrupt handshake
    input wire logic irq_ack,
    input wire logic irq_reti,
    output logic irq_req,
    output logic irq_high,
    output logic [NSRC-1:0] irq_sel,
    // Masked request vector and register contents
    output logic [NSRC-1:0] irq_pending,
    output logic [7:0] enable_out,
    output logic [7:0] priority_out
);

    // ==========================================================
    // Register storage and bus decode
    eip_vec_t enable_q;
    eip_vec_t enable_d;
    eip_vec_t priority_q;
    eip_vec_t priority_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic hit_d;

    // One-hot match of the two mapped addresses: bit 0 enable, bit 1 priority
    function automatic logic [1:0] sfr_match(input logic strobe, input logic [7:0] addr);
        logic [1:0] m;
        m[0] = strobe && (addr == `EIP_ADDR_ENABLE_ONE);
        m[1] = strobe && (addr == `EIP_ADDR_PRIORITY_ONE);
        return m;
    endfunction

    // Write data or hold, shared by both registers
    function automatic eip_vec_t reg_next(input logic we, input eip_vec_t d, input eip_vec_t q);
        return we ? d : q;
    endfunction

    wire logic [1:0] wr_hit = sfr_match(sfr_req.wr, sfr_req.addr);
    wire logic [1:0] rd_hit = sfr_match(sfr_req.rd, sfr_req.addr);
    wire logic wr_en = wr_hit[0];
    wire logic wr_pr = wr_hit[1];
    wire logic rd_en = rd_hit[0];
    wire logic rd_pr = rd_hit[1];
    wire logic [7:0] rd_mux = rd_en ? enable_q : (rd_pr ? priority_q : 8'h00);

    // ==========================================================
    // Write path
    // Writes take effect the next edge; software relies on single-cycle writes
    assign enable_d = reg_next(wr_en, sfr_req.wdata, enable_q);
    assign priority_d = reg_next(wr_pr, sfr_req.wdata, priority_q);

    // ==========================================================
    // Read path
    // Reads see the flops, so a write in the same cycle returns the old value
    assign rdata_d = rd_mux;
    assign hit_d = |wr_hit || |rd_hit;

    // ==========================================================
    // Register flops
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            enable_q <= `EIP_RESET_ENABLE_ONE;
        end else begin
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            priority_q <= `EIP_RESET_PRIORITY_ONE;
        end else begin
            priority_q <= priority_d;
        end
    end

    // Read data registered so it is stable one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_d;
        end
    end

    // ==========================================================
    // Source grouping
    // The two flags of timer3, cmp1, cmp0 and rtc share one enable bit and one priority bit
    function automatic logic pair_or(input logic a, input logic b);
        return a | b;
    endfunction

    // Pure AND gating: source flags live in their peripherals and stay set
    wire logic raw_timer3 = pair_or(src.timer3_low_overflow_flag, src.timer3_high_overflow_flag);
    wire logic raw_cmp1 = pair_or(src.cmp1_rise_flag, src.cmp1_fall_flag);
    wire logic raw_cmp0 = pair_or(src.cmp0_rise_flag, src.cmp0_fall_flag);
    wire logic raw_counter_array = src.counter_array_req;
    wire logic raw_adc_done = src.adc_done_flag;
    wire logic raw_adc_window = src.adc_window_flag;
    wire logic raw_rtc = pair_or(src.rtc_alarm_flag, src.rtc_osc_fail_flag);
    wire logic raw_twowire = src.twowire_req;

    // ==========================================================
    // Enable bits
    wire logic timer3_irq_enable = enable_q[`EIP_BIT_TIMER3];
    wire logic cmp1_irq_enable = enable_q[`EIP_BIT_CMP1];
    wire logic cmp0_irq_enable = enable_q[`EIP_BIT_CMP0];
    wire logic counter_array_irq_enable = enable_q[`EIP_BIT_COUNTER_ARRAY];
    wire logic adc_done_irq_enable = enable_q[`EIP_BIT_ADC_DONE];
    wire logic adc_window_irq_enable = enable_q[`EIP_BIT_ADC_WINDOW];
    wire logic rtc_irq_enable = enable_q[`EIP_BIT_RTC];
    wire logic twowire_irq_enable = enable_q[`EIP_BIT_TWOWIRE];

    // ==========================================================
    // Priority bits: zero is the low level, one the high level
    wire logic timer3_irq_priority = priority_q[`EIP_BIT_TIMER3];
    wire logic cmp1_irq_priority = priority_q[`EIP_BIT_CMP1];
    wire logic cmp0_irq_priority = priority_q[`EIP_BIT_CMP0];
    wire logic counter_array_irq_priority = priority_q[`EIP_BIT_COUNTER_ARRAY];
    wire logic adc_done_irq_priority = priority_q[`EIP_BIT_ADC_DONE];
    wire logic adc_window_irq_priority = priority_q[`EIP_BIT_ADC_WINDOW];
    wire logic rtc_irq_priority = priority_q[`EIP_BIT_RTC];
    wire logic twowire_irq_priority = priority_q[`EIP_BIT_TWOWIRE];

    // ==========================================================
    // Masking
    wire logic timer3_irq_masked = raw_timer3 & timer3_irq_enable;
    wire logic cmp1_irq_masked = raw_cmp1 & cmp1_irq_enable;
    wire logic cmp0_irq_masked = raw_cmp0 & cmp0_irq_enable;
    wire logic counter_array_irq_masked = raw_counter_array & counter_array_irq_enable;
    wire logic adc_done_irq_masked = raw_adc_done & adc_done_irq_enable;
    wire logic adc_window_irq_masked = raw_adc_window & adc_window_irq_enable;
    wire logic rtc_irq_masked = raw_rtc & rtc_irq_enable;
    wire logic twowire_irq_masked = raw_twowire & twowire_irq_enable;

    logic [7:0] masked;
    assign masked[`EIP_BIT_TIMER3] = timer3_irq_masked;
    assign masked[`EIP_BIT_CMP1] = cmp1_irq_masked;
    assign masked[`EIP_BIT_CMP0] = cmp0_irq_masked;
    assign masked[`EIP_BIT_COUNTER_ARRAY] = counter_array_irq_masked;
    assign masked[`EIP_BIT_ADC_DONE] = adc_done_irq_masked;
    assign masked[`EIP_BIT_ADC_WINDOW] = adc_window_irq_masked;
    assign masked[`EIP_BIT_RTC] = rtc_irq_masked;
    assign masked[`EIP_BIT_TWOWIRE] = twowire_irq_masked;

    logic [7:0] prio_vec;
    assign prio_vec[`EIP_BIT_TIMER3] = timer3_irq_priority;
    assign prio_vec[`EIP_BIT_CMP1] = cmp1_irq_priority;
    assign prio_vec[`EIP_BIT_CMP0] = cmp0_irq_priority;
    assign prio_vec[`EIP_BIT_COUNTER_ARRAY] = counter_array_irq_priority;
    assign prio_vec[`EIP_BIT_ADC_DONE] = adc_done_irq_priority;
    assign prio_vec[`EIP_BIT_ADC_WINDOW] = adc_window_irq_priority;
    assign prio_vec[`EIP_BIT_RTC] = rtc_irq_priority;
    assign prio_vec[`EIP_BIT_TWOWIRE] = twowire_irq_priority;

    // ==========================================================
    // Priority arbitration
    // Ack acts on the live choice; a source change in the ack cycle redirects it
    wire logic [NSRC-1:0] arb_req = masked[NSRC-1:0];
    wire logic [NSRC-1:0] arb_prio = prio_vec[NSRC-1:0];
    logic arb_valid;
    logic [NSRC-1:0] arb_sel;
    logic arb_high;

    eip_arbiter #(
        .NSRC(NSRC)
    ) u_arb (
        .mclk(mclk),
        .resetn(resetn),
        .req(arb_req),
        .prio(arb_prio),
        .ack(irq_ack),
        .reti(irq_reti),
        .sel_valid(arb_valid),
        .sel_onehot(arb_sel),
        .sel_high(arb_high),
        .level()
    );

    // ==========================================================
    // Registered outputs
    logic irq_req_q;
    logic irq_req_d;
    logic irq_high_q;
    logic irq_high_d;
    logic [NSRC-1:0] irq_sel_q;
    logic [NSRC-1:0] irq_sel_d;
    logic [NSRC-1:0] pending_q;
    logic [NSRC-1:0] pending_d;

    // One cycle of latency traded for flop-driven outputs
    assign irq_req_d = arb_valid;
    assign irq_high_d = arb_high;
    assign irq_sel_d = arb_sel;
    assign pending_d = arb_req;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_req_q <= 1'b0;
        end else begin
            irq_req_q <= irq_req_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_high_q <= 1'b0;
        end else begin
            irq_high_q <= irq_high_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_sel_q <= '0;
        end else begin
            irq_sel_q <= irq_sel_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pending_q <= '0;
        end else begin
            pending_q <= pending_d;
        end
    end

    // ==========================================================
    // Output ports
    assign irq_req = irq_req_q;
    assign irq_high = irq_high_q;
    assign irq_sel = irq_sel_q;
    assign irq_pending = pending_q;
    assign enable_out = enable_q;
    assign priority_out = priority_q;
    assign sfr_rdata = rdata_q;
    assign sfr_hit = hit_q;

    // ==========================================================
    // Elaboration checks
    // Field positions must stay inside the byte and apart from each other
    localparam logic [7:0] FIELD_MAP = (8'h01 << `EIP_BIT_TIMER3)
        | (8'h01 << `EIP_BIT_CMP1)
        | (8'h01 << `EIP_BIT_CMP0)
        | (8'h01 << `EIP_BIT_COUNTER_ARRAY)
        | (8'h01 << `EIP_BIT_ADC_DONE)
        | (8'h01 << `EIP_BIT_ADC_WINDOW)
        | (8'h01 << `EIP_BIT_RTC)
        | (8'h01 << `EIP_BIT_TWOWIRE);

    if (FIELD_MAP != 8'hFF) begin : g_bad_fields
        $error("eip_top: source bit positions overlap");
    end

    if (NSRC != 8) begin : g_bad_nsrc
        $error("eip_top: NSRC must be 8, one per register bit");
    end

endmodule
`default_nettype wire
